// ---- src/qec_pkg.sv ----
package qec_pkg;

    // ==========================================
    // geometry
    localparam int NUM_PINS = 8;
    localparam int NUM_DET = 8;
    localparam int NUM_ENC = 4;
    localparam int CNT_W = 32;
    localparam int NARROW_W = 16;

    // ==========================================
    // timing
    localparam int CLK_MHZ = 250;
    localparam int ENC_MAX_MHZ = 5;
    // smallest spacing of two phase edges, quarter of the fastest period
    localparam int ENC_EDGE_CYC = CLK_MHZ / (4 * ENC_MAX_MHZ);

    // ==========================================
    // register map, byte addresses
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CFG_OFS = 8'h10;
    localparam logic [7:0] LATCH_OFS = 8'h20;
    localparam logic [7:0] COUNT_OFS = 8'h30;
    localparam logic [7:0] ADDR_MASK = 8'hF0;

    // ctrl bits, both self clearing strobes
    localparam int CTRL_ACQ_BIT = 0;
    localparam int CTRL_SOS_BIT = 1;

    // cfg field positions
    localparam int CFG_MULT_LSB = 0;
    localparam int CFG_WIDE_BIT = 2;
    localparam int CFG_LSRC_BIT = 3;
    localparam int CFG_GATE_BIT = 4;
    localparam int CFG_CLR_BIT = 5;
    localparam int CFG_MAP_LSB = 6;
    localparam logic [9:0] CFG_RESET = 10'h000;

    // ==========================================
    // types
    typedef enum logic [1:0]
    {
        MULT_1X = 2'b00,
        MULT_2X = 2'b01,
        MULT_4X = 2'b10
    } qec_mult_e;

    typedef struct packed
    {
        logic [3:0] map_sel;
        logic index_clear_enable;
        logic gate_enable;
        logic latch_source_select;
        logic wide;
        logic [1:0] count_multiplier_select;
    } qec_cfg_s;

    typedef struct packed
    {
        logic [7:0] addr;
        logic write;
    } qec_aphase_s;

    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;

endpackage

// ---- src/qec_sync.sv ----
`timescale 1ns/1ns
module qec_sync
#(
    parameter int W = 8
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_r;

    // ==========================================
    // two stages, first stage read only by second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r <= '0;
            dout <= '0;
        end
        else if (ce)
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule

// ---- src/qec_chan.sv ----
`timescale 1ns/1ns
module qec_chan
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input qec_pkg::qec_cfg_s cfg,
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic map_sig,
    input wire logic sos,
    input wire logic acq_clr,
    output logic [qec_pkg::CNT_W-1:0] count_r,
    output logic [qec_pkg::CNT_W-1:0] latch_r
);

    logic a_d_r;
    logic b_d_r;
    logic map_d_r;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic map_rise;
    logic step;
    logic up;
    logic [qec_pkg::CNT_W-1:0] cnt_nxt;
    logic [qec_pkg::CNT_W-1:0] view;

    assign a_rise = phase_a & ~a_d_r;
    assign a_fall = ~phase_a & a_d_r;
    assign b_rise = phase_b & ~b_d_r;
    assign b_fall = ~phase_b & b_d_r;
    assign map_rise = map_sig & ~map_d_r;

    // ==========================================
    // edge history
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_d_r <= 1'b0;
            b_d_r <= 1'b0;
            map_d_r <= 1'b0;
        end
        else if (ce)
        begin
            a_d_r <= phase_a;
            b_d_r <= phase_b;
            map_d_r <= map_sig;
        end
    end

    // ==========================================
    // step and direction
    always_comb
    begin
        step = 1'b0;
        up = 1'b0;
        case (cfg.count_multiplier_select)
            qec_pkg::MULT_2X:
            begin
                step = a_rise | a_fall;
            end
            qec_pkg::MULT_4X:
            begin
                step = a_rise | a_fall | b_rise | b_fall;
            end
            default:
            begin
                step = a_rise;
            end
        endcase
        // a leading b: a rises with b low, b rises with a high
        if (a_rise | a_fall)
        begin
            up = (phase_a != phase_b);
        end
        else
        begin
            up = (phase_a == phase_b);
        end
    end

    always_comb
    begin
        cnt_nxt = up ? count_r + 32'h0000_0001 : count_r - 32'h0000_0001;
        if (!cfg.wide)
        begin
            cnt_nxt[qec_pkg::CNT_W-1:qec_pkg::NARROW_W] = '0;
        end
    end

    // narrow mode hides the upper half from the latch, and cnt_nxt clears it in count_r on every step; the live count is read from count_r unmasked
    assign view = cfg.wide ? count_r : {16'h0000, count_r[qec_pkg::NARROW_W-1:0]};

    // ==========================================
    // position counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_r <= qec_pkg::CNT_ZERO;
        end
        else if (ce)
        begin
            if (acq_clr)
            begin
                count_r <= qec_pkg::CNT_ZERO;
            end
            else if (cfg.index_clear_enable && map_rise)
            begin
                count_r <= qec_pkg::CNT_ZERO;
            end
            else if (step && (!cfg.gate_enable || map_sig))
            begin
                count_r <= cnt_nxt;
            end
        end
    end

    // ==========================================
    // held value for the scan
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            latch_r <= qec_pkg::CNT_ZERO;
        end
        else if (ce)
        begin
            if (acq_clr)
            begin
                latch_r <= qec_pkg::CNT_ZERO;
            end
            else if (cfg.latch_source_select ? map_rise : sos)
            begin
                latch_r <= view;
            end
        end
    end

endmodule

// ---- src/qec_top.sv ----
`timescale 1ns/1ns
// What this block does
// - two-bit select picks one of three multipliers
// - 1X rising A, 2X both A, 4X A and B
// - up when A leads, down when A lags
// - counter width selectable, 16 or 32 bits
// - track phases up to 5 MHz
// - four A/B encoders, or two with index
// - start of scan latches count by default
// - mapped edge latches when latch source selected
// - gate enabled: count only while mapped high
// - mapped channel: any input or detection signal
// - index clear: zero on mapped rising edge
// - acquisition start clears all counters
// - latched values served per selected scan channel
module qec_top
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [qec_pkg::NUM_PINS-1:0] enc_in,
    input wire logic [qec_pkg::NUM_DET-1:0] detect,
    input wire logic sos,
    input wire logic acq_start,
    input wire logic scan_rd,
    input wire logic [1:0] scan_sel,
    output logic [31:0] scan_data,
    output logic scan_valid
);

    logic [qec_pkg::NUM_PINS-1:0] pin_s;
    qec_pkg::qec_cfg_s cfg_r [qec_pkg::NUM_ENC];
    logic [qec_pkg::NUM_ENC-1:0] map_sig;
    logic [qec_pkg::CNT_W-1:0] count_w [qec_pkg::NUM_ENC];
    logic [qec_pkg::CNT_W-1:0] latch_w [qec_pkg::NUM_ENC];
    logic sw_acq_r;
    logic sw_sos_r;
    logic acq_clr;
    logic sos_any;
    logic seen_acq_r;
    logic pend_r;
    qec_pkg::qec_aphase_s aph_r;
    logic [31:0] rd_nxt;
    logic [1:0] idx;
    logic wr_cfg;
    logic wr_ctrl;
    logic [31:0] stat_w;

    assign acq_clr = acq_start | sw_acq_r;
    assign sos_any = sos | sw_sos_r;
    assign idx = aph_r.addr[3:2];
    // status: started flag, low detection signals, synced pins
    assign stat_w = {19'h0_0000, pin_s, detect[3:0], seen_acq_r};

    // ==========================================
    // pin synchronisers
    // edges at 5 MHz are 12 cycles apart, far above two-stage latency
    qec_sync #(.W(qec_pkg::NUM_PINS)) u_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .din(enc_in),
        .dout(pin_s)
    );

    // ==========================================
    // encoder channels, A on even pin, B on the next
    // an index occupies a spare pin, halving the encoders that fit
    genvar g;
    generate
        for (g = 0; g < qec_pkg::NUM_ENC; g++)
        begin : g_enc
            // upper half of the selector picks the detection signals
            assign map_sig[g] = cfg_r[g].map_sel[3] ? detect[cfg_r[g].map_sel[2:0]]
                                                    : pin_s[cfg_r[g].map_sel[2:0]];

            qec_chan u_chan
            (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .cfg(cfg_r[g]),
                .phase_a(pin_s[2*g]),
                .phase_b(pin_s[2*g+1]),
                .map_sig(map_sig[g]),
                .sos(sos_any),
                .acq_clr(acq_clr),
                .count_r(count_w[g]),
                .latch_r(latch_w[g])
            );
        end
    endgenerate

    // ==========================================
    // ahb address phase, one wait state for every transfer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_r <= 1'b0;
            aph_r <= '0;
        end
        else if (ce)
        begin
            if (pend_r)
            begin
                pend_r <= 1'b0;
            end
            else if (hsel && htrans[1] && hready)
            begin
                pend_r <= 1'b1;
                aph_r.addr <= haddr[7:0];
                aph_r.write <= hwrite;
            end
        end
    end

    // low only in the data phase cycle, so every transfer costs one wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
        end
        else if (ce)
        begin
            hreadyout <= pend_r || !(hsel && htrans[1] && hready);
        end
    end

    // ==========================================
    // register map, one aligned word each
    // 0x00 control, write only: bit 0 starts acquisition, bit 1 scan start
    // 0x04 status: started flag, detect[3:0], synced pins
    // 0x10 + 4k configuration of encoder k
    // 0x20 + 4k value latched for encoder k
    // 0x30 + 4k live count of encoder k
    // other offsets read zero and drop writes
    always_comb
    begin
        wr_cfg = 1'b0;
        wr_ctrl = 1'b0;
        if (pend_r && aph_r.write)
        begin
            wr_cfg = ((aph_r.addr & qec_pkg::ADDR_MASK) == qec_pkg::CFG_OFS);
            wr_ctrl = (aph_r.addr == qec_pkg::CTRL_OFS);
        end
    end

    // only okay answers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            hresp <= 1'b0;
        end
    end

    // ==========================================
    // register writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < qec_pkg::NUM_ENC; i++)
            begin
                cfg_r[i] <= qec_pkg::qec_cfg_s'(qec_pkg::CFG_RESET);
            end
        end
        else if (ce)
        begin
            if (wr_cfg)
            begin
                cfg_r[idx] <= qec_pkg::qec_cfg_s'(hwdata[9:0]);
            end
        end
    end

    // strobes last one cycle so a held bit cannot keep counters clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sw_acq_r <= 1'b0;
            sw_sos_r <= 1'b0;
        end
        else if (ce)
        begin
            sw_acq_r <= 1'b0;
            sw_sos_r <= 1'b0;
            if (wr_ctrl)
            begin
                sw_acq_r <= hwdata[qec_pkg::CTRL_ACQ_BIT];
                sw_sos_r <= hwdata[qec_pkg::CTRL_SOS_BIT];
            end
        end
    end

    // sticky: acquisition started since reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            seen_acq_r <= 1'b0;
        end
        else if (ce && acq_clr)
        begin
            seen_acq_r <= 1'b1;
        end
    end

    // ==========================================
    // register reads
    // taken from live state in the data phase, so status shows that cycle's pins
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        case (aph_r.addr & qec_pkg::ADDR_MASK)
            qec_pkg::CTRL_OFS:
            begin
                if (aph_r.addr == qec_pkg::STAT_OFS)
                begin
                    rd_nxt = stat_w;
                end
            end
            qec_pkg::CFG_OFS:
            begin
                rd_nxt = {22'h00_0000, cfg_r[idx]};
            end
            qec_pkg::LATCH_OFS:
            begin
                rd_nxt = latch_w[idx];
            end
            qec_pkg::COUNT_OFS:
            begin
                rd_nxt = count_w[idx];
            end
            default:
            begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // a write's data phase returns zero rather than stale read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (ce && pend_r)
        begin
            hrdata <= aph_r.write ? 32'h0000_0000 : rd_nxt;
        end
    end

    // ==========================================
    // scan readout toward the acquisition unit
    // the scan copies a held latch, never the live counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scan_data <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (scan_rd)
            begin
                scan_data <= latch_w[scan_sel];
            end
        end
    end

    // one pulse per read, one cycle late
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scan_valid <= 1'b0;
        end
        else if (ce)
        begin
            scan_valid <= scan_rd;
        end
    end

endmodule

// ---- tb/qec_properties.sv ----
`timescale 1ns/1ns
module qec_properties
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic acq_start,
    input wire logic scan_rd,
    input wire logic [31:0] scan_data,
    input wire logic scan_valid
);
    // ======
    // helpers
    logic taken;
    logic zero_adr;
    assign taken = ce & hsel & htrans[1] & hready;
    // ctrl is write only, everything from 0x40 up is unmapped
    assign zero_adr = (haddr[7:0] == qec_pkg::CTRL_OFS) || (haddr[7:0] >= 8'h40);

    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ======
    // bus
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    wait_one_a: assert property (taken |=> !hreadyout ##1 hreadyout)
        else $error("wait state not one cycle");
    ready_idle_a: assert property (!taken |=> hreadyout)
        else $error("hreadyout low without transfer");
    rdata_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata))
        else $error("hrdata moved outside completion");
    zero_read_a: assert property (taken && !hwrite && zero_adr |-> ##2 hrdata == 32'h0000_0000)
        else $error("ctrl or unmapped read not zero");

    // ======
    // scan port
    scan_pulse_a: assert property (scan_rd |=> scan_valid)
        else $error("scan read not answered");
    scan_quiet_a: assert property (!scan_rd |=> !scan_valid && $stable(scan_data))
        else $error("scan output moved without read");
    acq_clear_a: assert property (acq_start ##1 scan_rd |=> scan_data == 32'h0000_0000)
        else $error("latch not cleared by acquisition start");

    cover property (taken && hwrite);
    cover property (scan_valid);
    cover property (acq_start ##1 scan_rd);
endmodule

bind qec_top qec_properties qec_properties_i
(
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .acq_start, .scan_rd, .scan_data, .scan_valid
);

// ---- tb/qec_enc_model.sv ----
`timescale 1ns/1ns
module qec_enc_model
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic step,
    input wire logic fwd,
    output logic a,
    output logic b
);
    // ======
    // gray sequence: one phase moves per step, spacing set by caller
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a <= 1'b0;
            b <= 1'b0;
        end
        else if (step)
        begin
            // forward: a moves when equal to b, so a leads b
            if (fwd == (a == b))
                a <= ~a;
            else
                b <= ~b;
        end
    end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
        end \
    end
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hready;
    logic [1:0] strobe = '0;
    logic scan_rd = 1'b0;
    logic [1:0] scan_sel = '0;
    logic [31:0] scan_data;
    logic scan_valid;
    logic [7:0] detect = '0;
    logic [3:2] pin = '0;
    logic step = 1'b0;
    logic fwd = 1'b0;
    logic [1:0] pa;
    logic [1:0] pb;
    qec_pkg::qec_cfg_s c;
    int n_errors = 0;
    int n_compared = 0;

    always #2 hclk = ~hclk;

    qec_top qec_top_i
    (
        .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp(),
        .enc_in({pb[1], pa[1], 2'h0, pin, pb[0], pa[0]}), .detect,
        .sos(strobe[0]), .acq_start(strobe[1]), .scan_rd, .scan_sel, .scan_data, .scan_valid
    );
    // encoders 0 and 3 move together
    qec_enc_model qec_enc_model_i[1:0] (.hclk, .hresetn, .step, .fwd, .a(pa), .b(pb));

    // ======
    // tasks
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= 32'(a);
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        `CHK(nm, e, q)
    endtask

    task automatic scan(input logic [31:0] e);
        scan_rd <= 1'b1;
        scan_sel <= 2'h0;
        @(posedge hclk);
        scan_rd <= 1'b0;
        @(posedge hclk);
        `CHK("scan valid", 1'b1, scan_valid)
        `CHK("scan data", e, scan_data)
    endtask

    task automatic pulse(input int i);
        strobe[i] <= 1'b1;
        @(posedge hclk);
        strobe[i] <= 1'b0;
    endtask

    task automatic mv(input logic f, input int n, input int gap);
        repeat (n)
        begin
            step <= 1'b1;
            fwd <= f;
            @(posedge hclk);
            step <= 1'b0;
            repeat (gap) @(posedge hclk);
        end
    endtask

    // ======
    // sequence
    initial
    begin
        #100000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        repeat (10) @(posedge hclk);
        `CHK("ready in reset", 1'b1, hready)
        hresetn <= 1'b1;
        rd(qec_pkg::CFG_OFS, '0, "cfg reset");
        for (int m = 0; m < 3; m++)
        begin
            pulse(1);
            c = '0;
            c.wide = 1'b1;
            c.count_multiplier_select = 2'(m);
            wr(qec_pkg::CFG_OFS, 32'(c));
            wr(qec_pkg::CFG_OFS + 8'h0C, 32'(c));
            mv(1'b1, 8, qec_pkg::ENC_EDGE_CYC - 1);
            rd(qec_pkg::COUNT_OFS, 32'h0000_0002 << m, "fwd");
            rd(qec_pkg::COUNT_OFS + 8'h0C, 32'h0000_0002 << m, "fwd enc3");
            mv(1'b0, 12, 20);
            rd(qec_pkg::COUNT_OFS, -(32'h0000_0001 << m), "rev");
        end
        pulse(1);
        c.wide = 1'b0;
        wr(qec_pkg::CFG_OFS, 32'(c));
        mv(1'b0, 4, 11);
        rd(qec_pkg::COUNT_OFS, 32'h0000_FFFC, "narrow");
        mv(1'b1, 8, 11);
        rd(qec_pkg::COUNT_OFS, 32'h0000_0004, "wrap");
        pulse(0);
        scan(32'h0000_0004);
        mv(1'b1, 4, 11);
        rd(qec_pkg::LATCH_OFS, 32'h0000_0004, "latch held");
        wr(qec_pkg::CTRL_OFS, 32'h0000_0002);
        rd(qec_pkg::LATCH_OFS, 32'h0000_0008, "sw latch");
        rd(qec_pkg::CTRL_OFS, '0, "ctrl read");
        pulse(1);
        c.gate_enable = 1'b1;
        c.map_sel = 4'h3;
        wr(qec_pkg::CFG_OFS, 32'(c));
        mv(1'b1, 4, 11);
        rd(qec_pkg::COUNT_OFS, '0, "gated");
        pin[3] <= 1'b1;
        repeat (4) @(posedge hclk);
        mv(1'b1, 4, 11);
        rd(qec_pkg::COUNT_OFS, 32'h0000_0004, "ungated");
        c.gate_enable = 1'b0;
        c.index_clear_enable = 1'b1;
        c.map_sel = 4'h2;
        wr(qec_pkg::CFG_OFS, 32'(c));
        pin[2] <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(qec_pkg::COUNT_OFS, '0, "index clear");
        mv(1'b1, 4, 11);
        rd(qec_pkg::COUNT_OFS, 32'h0000_0004, "index level");
        pulse(1);
        scan('0);
        c.index_clear_enable = 1'b0;
        c.latch_source_select = 1'b1;
        c.map_sel = 4'h8;
        wr(qec_pkg::CFG_OFS, 32'(c));
        mv(1'b1, 4, 11);
        pulse(0);
        rd(qec_pkg::LATCH_OFS, '0, "sos ignored");
        detect[0] <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(qec_pkg::LATCH_OFS, 32'h0000_0004, "mapped latch");
        wr(qec_pkg::CTRL_OFS, 32'h0000_0001);
        rd(qec_pkg::COUNT_OFS, '0, "ctrl clear");
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, '0, "unmapped");
        rd(qec_pkg::STAT_OFS, 32'h0000_0183, "status");
        stop_test();
    end
endmodule
